// ---- src/dapg_port_top.sv ----
`timescale 1ns/1ps
`include "dapg_map.svh"

// Summary of operation
// (RULE_01) Mode 1: direction bits act as all ones, writes ignored, reads give ones.
// (RULE_02) Mode 1: low port drives address 7..0, high port address 15..8.
// (RULE_03) Mode 1 hardware standby: address pins released to high impedance.
// (RULE_04) Mode 2: direction one drives address or PWM; zero makes an input.
// (RULE_05) Mode 2: software sets direction bits before pins can drive.
// (RULE_06) Mode 3 low port: direction one drives latch or PWM per enable.
// (RULE_07) Mode 3 high port: direction one drives latch or PWM per enable.
// (RULE_08) Modes 2 and 3: direction registers write-only, reading all ones.
// (RULE_09) Direction registers clear on reset and hardware standby, hold in software standby.
// (RULE_10) Latch read gives latch where direction one, sampled pin where zero.
// (RULE_11) Latch registers clear on reset and hardware standby, hold in software standby.
// (RULE_12) Modes 2 and 3: pull-up on only when enable one and direction zero.
// (RULE_13) Pull-ups off in mode 1, during reset and hardware standby.
// (RULE_14) Pull-up registers read/write, clear on reset and hardware standby.
// (RULE_15) Every pin has its own pull-up enable bit.
// (RULE_16) Mode, standbys, PWM enables and PWM channels come from the chip.

module dapg_port_top
    import dapg_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        clk_en_i,
    // Chip level control
    input  wire logic [1:0]  mode_sel_i,
    input  wire logic        hw_standby_i,
    input  wire logic        sw_standby_i,
    input  wire logic        low_port_pwm_output_enable_i,
    input  wire logic        high_port_pwm_output_enable_i,
    input  wire logic [15:0] pwm_channel_i,
    input  wire logic [15:0] ext_addr_i,
    // Register port
    input  wire logic [15:0] reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic [7:0]       reg_rdata_o,
    // Low port pins
    input  wire logic [7:0]  low_pin_i,
    output logic [7:0]       low_pin_o,
    output logic [7:0]       low_pin_oe_o,
    output logic [7:0]       low_pullup_o,
    // High port pins
    input  wire logic [7:0]  high_pin_i,
    output logic [7:0]       high_pin_o,
    output logic [7:0]       high_pin_oe_o,
    output logic [7:0]       high_pullup_o
);

    dapg_mode_e mode;
    logic       mode_1;

    logic       wr_low_pullup;
    logic       wr_high_pullup;
    logic       wr_low_dir;
    logic       wr_high_dir;
    logic       wr_low_latch;
    logic       wr_high_latch;

    dapg_byte_t low_port_pullup_enable_q;
    dapg_byte_t high_port_pullup_enable_q;
    dapg_byte_t low_port_direction_q;
    dapg_byte_t high_port_direction_q;
    dapg_byte_t low_port_output_latch_q;
    dapg_byte_t high_port_output_latch_q;

    dapg_byte_t low_dir_eff;
    dapg_byte_t high_dir_eff;
    dapg_byte_t low_pin_q;
    dapg_byte_t high_pin_q;
    dapg_byte_t low_latch_view;
    dapg_byte_t high_latch_view;
    dapg_byte_t rdata_d;
    logic       sw_standby_q;

    // Mode decode, unused code 0 falls back to mode 1
    always_comb begin
        unique case (mode_sel_i)                                   // RULE_16
            `DAPG_MODE_SEL_2: mode = DAPG_MODE_2;
            `DAPG_MODE_SEL_3: mode = DAPG_MODE_3;
            `DAPG_MODE_SEL_1: mode = DAPG_MODE_1;
            default:          mode = DAPG_MODE_1;
        endcase
    end

    assign mode_1 = (mode == DAPG_MODE_1);

    // Write decode, low port; direction writes dropped in mode 1, stored value kept
    always_comb begin
        wr_low_pullup = 1'b0;
        wr_low_dir    = 1'b0;
        wr_low_latch  = 1'b0;
        if (reg_we_i) begin
            case (reg_addr_i)
                `DAPG_ADDR_LOW_PULLUP: wr_low_pullup = 1'b1;
                `DAPG_ADDR_LOW_DIR:    wr_low_dir    = !mode_1;    // RULE_01
                `DAPG_ADDR_LOW_LATCH:  wr_low_latch  = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // Write decode, high port
    always_comb begin
        wr_high_pullup = 1'b0;
        wr_high_dir    = 1'b0;
        wr_high_latch  = 1'b0;
        if (reg_we_i) begin
            case (reg_addr_i)
                `DAPG_ADDR_HIGH_PULLUP: wr_high_pullup = 1'b1;
                `DAPG_ADDR_HIGH_DIR:    wr_high_dir    = !mode_1;  // RULE_01
                `DAPG_ADDR_HIGH_LATCH:  wr_high_latch  = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // Direction as seen by the pin logic
    // Mode 1 overrides the stored value, which is kept
    assign low_dir_eff  = mode_1 ? `DAPG_ALL_ONES : low_port_direction_q;  // RULE_01
    assign high_dir_eff = mode_1 ? `DAPG_ALL_ONES : high_port_direction_q; // RULE_01

    // Pull-up enable registers
    // Standby clear wins over a write in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_port_pullup_enable_q <= `DAPG_RST_BYTE;            // RULE_14
        end else if (clk_en_i) begin
            if (hw_standby_i) begin
                low_port_pullup_enable_q <= `DAPG_RST_BYTE;        // RULE_14
            end else if (wr_low_pullup) begin
                low_port_pullup_enable_q <= reg_wdata_i;           // RULE_14 RULE_15
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_port_pullup_enable_q <= `DAPG_RST_BYTE;           // RULE_14
        end else if (clk_en_i) begin
            if (hw_standby_i) begin
                high_port_pullup_enable_q <= `DAPG_RST_BYTE;       // RULE_14
            end else if (wr_high_pullup) begin
                high_port_pullup_enable_q <= reg_wdata_i;          // RULE_14 RULE_15
            end
        end
    end

    // Direction registers, held through software standby
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_port_direction_q <= `DAPG_RST_BYTE;                // RULE_09
        end else if (clk_en_i) begin
            if (hw_standby_i) begin
                low_port_direction_q <= `DAPG_RST_BYTE;            // RULE_09
            end else if (wr_low_dir) begin
                low_port_direction_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_port_direction_q <= `DAPG_RST_BYTE;               // RULE_09
        end else if (clk_en_i) begin
            if (hw_standby_i) begin
                high_port_direction_q <= `DAPG_RST_BYTE;           // RULE_09
            end else if (wr_high_dir) begin
                high_port_direction_q <= reg_wdata_i;
            end
        end
    end

    // Output latches
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_port_output_latch_q <= `DAPG_RST_BYTE;             // RULE_11
        end else if (clk_en_i) begin
            if (hw_standby_i) begin
                low_port_output_latch_q <= `DAPG_RST_BYTE;         // RULE_11
            end else if (wr_low_latch) begin
                low_port_output_latch_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_port_output_latch_q <= `DAPG_RST_BYTE;            // RULE_11
        end else if (clk_en_i) begin
            if (hw_standby_i) begin
                high_port_output_latch_q <= `DAPG_RST_BYTE;        // RULE_11
            end else if (wr_high_latch) begin
                high_port_output_latch_q <= reg_wdata_i;
            end
        end
    end

    // Pin levels for data register reads, one cycle old
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_pin_q <= `DAPG_RST_BYTE;
        end else if (clk_en_i) begin
            low_pin_q <= low_pin_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_pin_q <= `DAPG_RST_BYTE;
        end else if (clk_en_i) begin
            high_pin_q <= high_pin_i;
        end
    end

    // Software standby seen for status only, registers keep state
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sw_standby_q <= 1'b0;
        end else if (clk_en_i) begin
            sw_standby_q <= sw_standby_i;
        end
    end

    // Data register read view: latch where the pin drives, pin level where it listens
    always_comb begin
        low_latch_view = (low_dir_eff & low_port_output_latch_q) | (~low_dir_eff & low_pin_q);      // RULE_10
    end

    always_comb begin
        high_latch_view = (high_dir_eff & high_port_output_latch_q) | (~high_dir_eff & high_pin_q); // RULE_10
    end

    // Read mux
    always_comb begin
        rdata_d = `DAPG_UNMAPPED_READ;
        case (reg_addr_i)
            `DAPG_ADDR_LOW_PULLUP:  rdata_d = low_port_pullup_enable_q;  // RULE_14
            `DAPG_ADDR_HIGH_PULLUP: rdata_d = high_port_pullup_enable_q; // RULE_14
            `DAPG_ADDR_LOW_DIR:     rdata_d = `DAPG_ALL_ONES;            // RULE_01 RULE_08
            `DAPG_ADDR_HIGH_DIR:    rdata_d = `DAPG_ALL_ONES;            // RULE_01 RULE_08
            `DAPG_ADDR_LOW_LATCH:   rdata_d = low_latch_view;            // RULE_10
            `DAPG_ADDR_HIGH_LATCH:  rdata_d = high_latch_view;           // RULE_10
            default: begin
                rdata_d = `DAPG_UNMAPPED_READ;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    // Idle cycles with clk_en_i high return zero; while clk_en_i is low the last data is held
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= `DAPG_RST_BYTE;
        end else if (clk_en_i) begin
            if (reg_re_i) begin
                reg_rdata_o <= rdata_d;
            end else begin
                reg_rdata_o <= `DAPG_RST_BYTE;
            end
        end
    end

    // Low port pin driver
    dapg_pin_drv u_low_drv (
        .clk_i               (clk_i),
        .reset_n_i           (reset_n_i),
        .clk_en_i            (clk_en_i),
        .mode_i              (mode),
        .hw_standby_i        (hw_standby_i),
        .pwm_output_enable_i (low_port_pwm_output_enable_i),
        .dir_i               (low_dir_eff),
        .latch_i             (low_port_output_latch_q),
        .pullup_en_i         (low_port_pullup_enable_q),
        .addr_i              (ext_addr_i[7:0]),
        .pwm_i               (pwm_channel_i[7:0]),
        .pin_o               (low_pin_o),
        .pin_oe_o            (low_pin_oe_o),
        .pullup_o            (low_pullup_o)
    );

    // High port pin driver
    dapg_pin_drv u_high_drv (
        .clk_i               (clk_i),
        .reset_n_i           (reset_n_i),
        .clk_en_i            (clk_en_i),
        .mode_i              (mode),
        .hw_standby_i        (hw_standby_i),
        .pwm_output_enable_i (high_port_pwm_output_enable_i),
        .dir_i               (high_dir_eff),
        .latch_i             (high_port_output_latch_q),
        .pullup_en_i         (high_port_pullup_enable_q),
        .addr_i              (ext_addr_i[15:8]),
        .pwm_i               (pwm_channel_i[15:8]),
        .pin_o               (high_pin_o),
        .pin_oe_o            (high_pin_oe_o),
        .pullup_o            (high_pullup_o)
    );

endmodule

// ---- src/dapg_map.svh ----
`ifndef DAPG_MAP_SVH
`define DAPG_MAP_SVH

// Register byte addresses
`define DAPG_ADDR_LOW_PULLUP   16'hffac
`define DAPG_ADDR_HIGH_PULLUP  16'hffad
`define DAPG_ADDR_LOW_DIR      16'hffb0
`define DAPG_ADDR_HIGH_DIR     16'hffb1
`define DAPG_ADDR_LOW_LATCH    16'hffb2
`define DAPG_ADDR_HIGH_LATCH   16'hffb3

// Reset and fixed values
`define DAPG_RST_BYTE          8'h00
`define DAPG_ALL_ONES          8'hff
`define DAPG_UNMAPPED_READ     8'h00

// Operating mode select codes
`define DAPG_MODE_SEL_1        2'h1
`define DAPG_MODE_SEL_2        2'h2
`define DAPG_MODE_SEL_3        2'h3

`endif

// ---- src/dapg_pkg.sv ----
package dapg_pkg;

    typedef enum logic [2:0] {
        DAPG_MODE_1 = 3'b001,
        DAPG_MODE_2 = 3'b010,
        DAPG_MODE_3 = 3'b100
    } dapg_mode_e;

    typedef logic [7:0] dapg_byte_t;

endpackage

// ---- src/dapg_pin_drv.sv ----
`timescale 1ns/1ps
`include "dapg_map.svh"

module dapg_pin_drv
    import dapg_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       clk_en_i,
    // Control
    input  wire dapg_mode_e mode_i,
    input  wire logic       hw_standby_i,
    input  wire logic       pwm_output_enable_i,
    input  wire dapg_byte_t dir_i,
    input  wire dapg_byte_t latch_i,
    input  wire dapg_byte_t pullup_en_i,
    input  wire dapg_byte_t addr_i,
    input  wire dapg_byte_t pwm_i,
    // Pins
    output logic [7:0]      pin_o,
    output logic [7:0]      pin_oe_o,
    output logic [7:0]      pullup_o
);

    dapg_byte_t pin_d;
    dapg_byte_t oe_d;
    dapg_byte_t pull_d;

    always_comb begin
        pin_d  = `DAPG_RST_BYTE;
        oe_d   = `DAPG_RST_BYTE;
        pull_d = `DAPG_RST_BYTE;
        unique case (mode_i)
            DAPG_MODE_1: begin
                pin_d = addr_i;                                    // RULE_02
                oe_d  = hw_standby_i ? `DAPG_RST_BYTE : `DAPG_ALL_ONES; // RULE_03
            end
            DAPG_MODE_2: begin
                pin_d  = pwm_output_enable_i ? pwm_i : addr_i;     // RULE_04
                oe_d   = dir_i;                                    // RULE_04
                pull_d = pullup_en_i & ~dir_i;                     // RULE_12 RULE_15
            end
            DAPG_MODE_3: begin
                pin_d  = pwm_output_enable_i ? pwm_i : latch_i;    // RULE_06 RULE_07
                oe_d   = dir_i;                                    // RULE_06
                pull_d = pullup_en_i & ~dir_i;                     // RULE_12 RULE_15
            end
            default: begin
                pin_d = addr_i;
                oe_d  = `DAPG_RST_BYTE;
            end
        endcase
        if (hw_standby_i) begin
            oe_d   = `DAPG_RST_BYTE;
            pull_d = `DAPG_RST_BYTE;                               // RULE_13
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_o    <= `DAPG_RST_BYTE;
            pin_oe_o <= `DAPG_RST_BYTE;
            pullup_o <= `DAPG_RST_BYTE;                            // RULE_13
        end else if (clk_en_i) begin
            pin_o    <= pin_d;
            pin_oe_o <= oe_d;
            pullup_o <= pull_d;
        end
    end

endmodule

// ---- testbench/dapg_port_asserts.sv ----
`timescale 1ns/1ps
module dapg_port_asserts (
    // Clock, reset, enable
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        clk_en_i,
    // Chip control
    input wire logic [1:0]  mode_sel_i,
    input wire logic        hw_standby_i,
    input wire logic        low_port_pwm_output_enable_i,
    input wire logic        high_port_pwm_output_enable_i,
    input wire logic [15:0] pwm_channel_i,
    input wire logic [15:0] ext_addr_i,
    // Register port
    input wire logic [15:0] reg_addr_i,
    input wire logic        reg_re_i,
    input wire logic [7:0]  reg_rdata_o,
    // Pins
    input wire logic [7:0]  low_pin_o,
    input wire logic [7:0]  low_pin_oe_o,
    input wire logic [7:0]  low_pullup_o,
    input wire logic [7:0]  high_pin_o,
    input wire logic [7:0]  high_pin_oe_o,
    input wire logic [7:0]  high_pullup_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || !clk_en_i);
    wire m1 = mode_sel_i < 2'h2;
    sequence s_hw_pcr_read;
        hw_standby_i ##1 (hw_standby_i && reg_re_i && reg_addr_i == 16'hffac);
    endsequence
    a_addr_drive: assert property (m1 && !hw_standby_i |=>
        {high_pin_o, low_pin_o} == $past(ext_addr_i) && low_pin_oe_o == 8'hff) else $error("address out");
    a_addr_release: assert property (m1 && hw_standby_i |=>
        {high_pin_oe_o, low_pin_oe_o} == 16'h0000) else $error("address not released");
    a_pullup_off: assert property (m1 || hw_standby_i |=>
        {high_pullup_o, low_pullup_o} == 16'h0000) else $error("pull-up on");
    a_pullup_input: assert property (((low_pullup_o & low_pin_oe_o)
        | (high_pullup_o & high_pin_oe_o)) == 8'h00) else $error("pull-up on output");
    a_low_pwm_out: assert property (!m1 && low_port_pwm_output_enable_i |=>
        ((low_pin_o ^ $past(pwm_channel_i[7:0])) & low_pin_oe_o) == 8'h00) else $error("low pwm");
    a_high_pwm_out: assert property (!m1 && high_port_pwm_output_enable_i |=>
        ((high_pin_o ^ $past(pwm_channel_i[15:8])) & high_pin_oe_o) == 8'h00) else $error("high pwm");
    a_dir_read: assert property (reg_re_i && reg_addr_i[15:1] == 15'h7fd8 |=>
        reg_rdata_o == 8'hff) else $error("direction read");
    a_pcr_cleared: assert property (s_hw_pcr_read |=> reg_rdata_o == 8'h00)
        else $error("pull-up not cleared");
endmodule

bind dapg_port_top dapg_port_asserts u_dapg_port_asserts (.*);

// ---- testbench/dapg_pin_env.sv ----
`timescale 1ns/1ps
module dapg_pin_env (
    // Port side
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    // Far side drive
    input  wire logic [7:0] ext_i,
    input  wire logic       ext_en_i,
    // Wire level
    output logic [7:0]      level_o
);
    // Floating bit without pull-up shows inverse of port value
    assign level_o = (oe_i & drv_i) | (~oe_i & (ext_en_i ? ext_i : (pu_i | ~drv_i)));
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        clk_i, reset_n_i, hw_standby_i, sw_standby_i, reg_we_i, reg_re_i, ext_en;
    logic        low_port_pwm_output_enable_i, high_port_pwm_output_enable_i;
    logic        clk_en_i = 1'b1;
    logic [1:0]  mode_sel_i;
    logic [15:0] pwm_channel_i, ext_addr_i, reg_addr_i;
    logic [7:0]  reg_wdata_i, reg_rdata_o, ext, low_pin_i, low_pin_o, low_pin_oe_o, low_pullup_o;
    logic [7:0]  high_pin_i, high_pin_o, high_pin_oe_o, high_pullup_o;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;

    dapg_port_top u_dapg_port_top (.*);
    dapg_pin_env u_low_env (.drv_i(low_pin_o), .oe_i(low_pin_oe_o), .pu_i(low_pullup_o),
        .ext_i(ext), .ext_en_i(ext_en), .level_o(low_pin_i));
    dapg_pin_env u_high_env (.drv_i(high_pin_o), .oe_i(high_pin_oe_o), .pu_i(high_pullup_o),
        .ext_i(ext), .ext_en_i(ext_en), .level_o(high_pin_i));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task stop_test;
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata_o);
    endtask

    task settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    initial begin
        reset_n_i = 1'b0;
        mode_sel_i = 2'h2;
        {hw_standby_i, sw_standby_i, reg_we_i, reg_re_i} = 4'h0;
        {low_port_pwm_output_enable_i, high_port_pwm_output_enable_i} = 2'b00;
        pwm_channel_i = 16'habcd;
        ext_addr_i = 16'h1234;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 8'h00;
        ext = 8'h5a;
        ext_en = 1'b1;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // Mode 2 from reset
        rd(16'hffac, 8'h00);
        rd(16'hffad, 8'h00);
        rd(16'hffb2, 8'h5a);
        chk("low_oe", 8'h00, low_pin_oe_o);
        wr(16'hffac, 8'hf0);
        wr(16'hffb0, 8'h0f);
        settle();
        chk("low_oe", 8'h0f, low_pin_oe_o);
        chk("low_pin", 8'h04, low_pin_o & 8'h0f);
        chk("low_pu", 8'hf0, low_pullup_o);
        rd(16'hffb0, 8'hff);
        @(posedge clk_i) low_port_pwm_output_enable_i <= 1'b1;
        settle();
        chk("low_pin", 8'h0d, low_pin_o & 8'h0f);
        wr(16'hffb2, 8'ha5);
        @(posedge clk_i) ext_en <= 1'b0;
        settle();
        rd(16'hffb2, 8'hf5);
        // Software standby keeps state
        @(posedge clk_i) sw_standby_i <= 1'b1;
        settle();
        rd(16'hffac, 8'hf0);
        rd(16'hffb2, 8'hf5);
        chk("low_pu", 8'hf0, low_pullup_o);
        chk("low_oe", 8'h0f, low_pin_oe_o);
        @(posedge clk_i) sw_standby_i <= 1'b0;
        // Mode 3
        @(posedge clk_i) mode_sel_i <= 2'h3;
        wr(16'hffad, 8'hff);
        wr(16'hffb1, 8'hff);
        wr(16'hffb3, 8'h96);
        settle();
        chk("high_pin", 8'h96, high_pin_o);
        chk("high_oe", 8'hff, high_pin_oe_o);
        chk("high_pu", 8'h00, high_pullup_o);
        chk("low_pin", 8'h0d, low_pin_o & 8'h0f);
        @(posedge clk_i) {low_port_pwm_output_enable_i, high_port_pwm_output_enable_i} <= 2'b01;
        settle();
        chk("low_pin", 8'h05, low_pin_o & 8'h0f);
        chk("high_pin", 8'hab, high_pin_o);
        // Hardware standby clears
        @(posedge clk_i) hw_standby_i <= 1'b1;
        settle();
        chk("low_oe", 8'h00, low_pin_oe_o);
        chk("low_pu", 8'h00, low_pullup_o);
        rd(16'hffac, 8'h00);
        @(posedge clk_i) hw_standby_i <= 1'b0;
        settle();
        chk("low_oe", 8'h00, low_pin_oe_o);
        wr(16'hffb1, 8'hff);
        rd(16'hffb3, 8'h00);
        // Mode 1
        @(posedge clk_i) mode_sel_i <= 2'h1;
        wr(16'hffac, 8'hff);
        wr(16'hffb0, 8'hff);
        settle();
        chk("low_oe", 8'hff, low_pin_oe_o);
        chk("low_pin", 8'h34, low_pin_o);
        chk("high_pin", 8'h12, high_pin_o);
        chk("low_pu", 8'h00, low_pullup_o);
        rd(16'hffb0, 8'hff);
        wr(16'hffb2, 8'h77);
        rd(16'hffb2, 8'h77);
        // Leave mode 1: the ignored write must not have set the direction bits
        @(posedge clk_i) mode_sel_i <= 2'h3;
        settle();
        chk("low_oe", 8'h00, low_pin_oe_o);
        chk("low_pu", 8'hff, low_pullup_o);
        // Unused mode code behaves as mode 1
        @(posedge clk_i) mode_sel_i <= 2'h0;
        settle();
        chk("low_oe", 8'hff, low_pin_oe_o);
        @(posedge clk_i) hw_standby_i <= 1'b1;
        settle();
        chk("low_oe", 8'h00, low_pin_oe_o);
        chk("high_oe", 8'h00, high_pin_oe_o);
        @(posedge clk_i) hw_standby_i <= 1'b0;
        rd(16'hffaf, 8'h00);
        // Reset in mid-run clears the registers again
        wr(16'hffac, 8'h3c);
        wr(16'hffb2, 8'h81);
        rd(16'hffac, 8'h3c);
        @(posedge clk_i) reset_n_i <= 1'b0;
        @(posedge clk_i) reset_n_i <= 1'b1;
        rd(16'hffac, 8'h00);
        rd(16'hffb2, 8'h00);
        settle();
        chk("low_pin", 8'h34, low_pin_o);
        stop_test();
    end
endmodule
